// *** common/hsw_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the status words.
// Assumes one 40 MHz clock and AXI4-Lite byte addresses of four times the index.
`ifndef HSW_CFG_SVH
`define HSW_CFG_SVH

// ----------------------------------------------------------------
// Register indexes (byte address = index * 4)
// ----------------------------------------------------------------
`define HSW_IDX_HOLD        6'h09
`define HSW_IDX_LOOP        6'h0b
`define HSW_IDX_EXP_ERR     6'h0f
`define HSW_IDX_EXP_ALARM   6'h10
`define HSW_IDX_IRQ_STAT    6'h20
`define HSW_IDX_IRQ_MASK    6'h21
`define HSW_IDX_MONITOR     6'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HSW_HOLD_ONE_BIT    0
`define HSW_HOLD_TWO_BIT    4
`define HSW_MON_TWO_LSB     16
`define HSW_EV_HOLD_ONE     0
`define HSW_EV_HOLD_TWO     1
`define HSW_EV_LOOP         2
`define HSW_EV_EXP_ERR      3
`define HSW_EV_EXP_ALARM    4

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define HSW_IRQ_RST         5'h00
// Pin stage reset: sensor-present bits high, all else low
`define HSW_PIN_RST         8'h0c
`define HSW_RESP_OKAY       2'h0
`define HSW_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HSW_MIN_ON_MS       100
`define HSW_CLK_KHZ         40000
`define HSW_MIN_ON_CYC      (`HSW_MIN_ON_MS * `HSW_CLK_KHZ)

`endif

// *** common/hsw_pkg.sv ***
// Types shared by the status word block.
// Assumes hsw_cfg.svh supplies the numbers.
`default_nettype none

package hsw_pkg;

    // ON-time tracker, Gray along idle -> short -> long
    typedef enum logic [1:0]
    {
        HSW_ON_IDLE  = 2'h0,
        HSW_ON_SHORT = 2'h1,
        HSW_ON_LONG  = 2'h3
    } hsw_on_e;

    typedef logic [1:0] hsw_resp_t;
    typedef logic [4:0] hsw_irq_t;

endpackage

`default_nettype wire

// *** hdl/hsw_hold_mon.sv ***
// One heater-current monitor with its hold flag.
// Assumes all inputs are already on the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "hsw_cfg.svh"

module hsw_hold_mon #(
    parameter int              CUR_W  = 12,
    parameter int              CNT_W  = 22,
    parameter logic [CNT_W-1:0] MIN_ON = CNT_W'(`HSW_MIN_ON_CYC)
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Conditions
    input  wire logic             out_on,
    input  wire logic             sensor_ok,
    input  wire logic             freeze,
    input  wire logic [CUR_W-1:0] sample,
    // Results
    output logic                  hold,
    output logic      [CUR_W-1:0] value
);

    hsw_pkg::hsw_on_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             hold_reg, hold_next;
    logic [CUR_W-1:0] value_reg, value_next;

    // ----------------------------------------------------------------
    // ON-time measurement and update
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        hold_next  = hold_reg;
        value_next = value_reg;
        case (state_reg)
            hsw_pkg::HSW_ON_IDLE:
            begin
                cnt_next = '0;
                if (out_on)
                    state_next = hsw_pkg::HSW_ON_SHORT;
            end
            hsw_pkg::HSW_ON_SHORT:
            begin
                if (!out_on)
                begin
                    state_next = hsw_pkg::HSW_ON_IDLE;
                    hold_next  = 1'b1;
                end
                else if (cnt_reg >= MIN_ON - CNT_W'(1))
                    state_next = hsw_pkg::HSW_ON_LONG;
                else
                    cnt_next = cnt_reg + CNT_W'(1);
            end
            hsw_pkg::HSW_ON_LONG:
            begin
                if (!out_on)
                begin
                    state_next = hsw_pkg::HSW_ON_IDLE;
                    hold_next  = 1'b0;
                    value_next = sample;
                end
            end
            default:
                state_next = hsw_pkg::HSW_ON_IDLE;
        endcase
        // Missing sensor or supply frequency error freezes the value
        if (!sensor_ok || freeze)
        begin
            hold_next  = 1'b1;
            value_next = value_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= hsw_pkg::HSW_ON_IDLE;
            cnt_reg   <= '0;
            hold_reg  <= 1'b0;
            value_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            hold_reg  <= hold_next;
            value_reg <= value_next;
        end
    end

    assign hold  = hold_reg;
    assign value = value_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_short_fall;
        state_reg == hsw_pkg::HSW_ON_SHORT && !out_on;
    endsequence

    sequence s_long_fall;
        state_reg == hsw_pkg::HSW_ON_LONG && !out_on && sensor_ok && !freeze;
    endsequence

    a_short_hold: assert property (s_short_fall |=> hold && $stable(value))
        else $error("short ON pulse did not hold monitor");
    a_long_update: assert property (s_long_fall |=> !hold && value == $past(sample))
        else $error("long ON pulse did not update monitor");
    a_hold_absent: assert property (!sensor_ok || freeze |=> hold && $stable(value))
        else $error("absent sensor or freeze did not hold monitor");

endmodule

`default_nettype wire

// *** hdl/hsw_status_top.sv ***
// Heater unit status words behind an AXI4-Lite slave, with interrupt.
// Assumes field inputs are asynchronous pins except the current samples,
// which come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hsw_cfg.svh"

module hsw_status_top #(
    parameter int              AW     = 8,
    parameter int              CUR_W  = 12,
    parameter int              NUNIT  = 8,
    parameter int              CNT_W  = 22,
    parameter logic [CNT_W-1:0] MIN_ON = CNT_W'(`HSW_MIN_ON_CYC)
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // AXI4-Lite write
    input  wire logic [AW-1:0]    s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output hsw_pkg::hsw_resp_t    s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [AW-1:0]    s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic      [31:0]      s_axi_rdata,
    output hsw_pkg::hsw_resp_t    s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Heater current monitors
    input  wire logic [1:0]       ctrl_out_on,
    input  wire logic [1:0]       sensor_present,
    input  wire logic [CUR_W-1:0] cur_sample_one,
    input  wire logic [CUR_W-1:0] cur_sample_two,
    // Control loops
    input  wire logic [3:0]       loop_err,
    // Expansion units
    input  wire logic [NUNIT-1:0] unit_zero_cross_err,
    input  wire logic [NUNIT-1:0] unit_freq_err,
    input  wire logic [NUNIT-1:0] unit_burnout,
    input  wire logic [NUNIT-1:0] unit_overcurrent,
    input  wire logic [NUNIT-1:0] unit_ssr_short,
    input  wire logic [NUNIT-1:0] unit_ssr_open,
    // Interrupt
    output logic                  irq
);

    localparam int PIN_W = 8 + 6 * NUNIT;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_reg <= PIN_W'(`HSW_PIN_RST);
            pin_s2_reg <= PIN_W'(`HSW_PIN_RST);
        end
        else
        begin
            pin_s1_reg <= {unit_ssr_open, unit_ssr_short, unit_overcurrent,
                           unit_burnout, unit_freq_err, unit_zero_cross_err,
                           loop_err, sensor_present, ctrl_out_on};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic [1:0]       on_s, present_s;
    logic [3:0]       loop_s;
    logic [NUNIT-1:0] zc_s, freq_s, burn_s, ovc_s, short_s, open_s;

    assign {open_s, short_s, ovc_s, burn_s, freq_s, zc_s,
            loop_s, present_s, on_s} = pin_s2_reg;

    // ----------------------------------------------------------------
    // Heater current monitors
    // ----------------------------------------------------------------
    logic             hold_one, hold_two;
    logic [CUR_W-1:0] mon_one, mon_two;
    logic             freq_any;

    assign freq_any = |freq_s;

    hsw_hold_mon #(.CUR_W(CUR_W), .CNT_W(CNT_W), .MIN_ON(MIN_ON)) u_mon_one (
        .clock     (clock),
        .rst_b     (rst_b),
        .out_on    (on_s[0]),
        .sensor_ok (present_s[0]),
        .freeze    (freq_any),
        .sample    (cur_sample_one),
        .hold      (hold_one),
        .value     (mon_one)
    );

    hsw_hold_mon #(.CUR_W(CUR_W), .CNT_W(CNT_W), .MIN_ON(MIN_ON)) u_mon_two (
        .clock     (clock),
        .rst_b     (rst_b),
        .out_on    (on_s[1]),
        .sensor_ok (present_s[1]),
        .freeze    (freq_any),
        .sample    (cur_sample_two),
        .hold      (hold_two),
        .value     (mon_two)
    );

    // ----------------------------------------------------------------
    // Status words and interrupt
    // ----------------------------------------------------------------
    logic [3:0]       loop_reg, loop_next;
    logic [NUNIT-1:0] err_reg, err_next, alarm_reg, alarm_next;
    logic             hold1_d_reg, hold2_d_reg;
    hsw_pkg::hsw_irq_t irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
    hsw_pkg::hsw_irq_t ev;
    logic             irq_reg, irq_next;
    logic [15:0]      hold_word;
    logic             stat_clr, mask_wr;
    logic [31:0]      wdata_reg;

    always_comb
    begin
        hold_word = '0;
        hold_word[`HSW_HOLD_ONE_BIT] = hold_one;
        hold_word[`HSW_HOLD_TWO_BIT] = hold_two;
        loop_next  = loop_s;
        err_next   = zc_s;
        alarm_next = burn_s | ovc_s | short_s | open_s;
        ev = '0;
        ev[`HSW_EV_HOLD_ONE]  = hold_one & ~hold1_d_reg;
        ev[`HSW_EV_HOLD_TWO]  = hold_two & ~hold2_d_reg;
        ev[`HSW_EV_LOOP]      = |(loop_next & ~loop_reg);
        ev[`HSW_EV_EXP_ERR]   = |(err_next & ~err_reg);
        ev[`HSW_EV_EXP_ALARM] = |(alarm_next & ~alarm_reg);
        // New events win over the clearing read
        irq_stat_next = (irq_stat_reg & ~{5{stat_clr}}) | ev;
        irq_mask_next = mask_wr ? wdata_reg[4:0] : irq_mask_reg;
        irq_next      = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_reg     <= '0;
            err_reg      <= '0;
            alarm_reg    <= '0;
            hold1_d_reg  <= 1'b0;
            hold2_d_reg  <= 1'b0;
            irq_stat_reg <= `HSW_IRQ_RST;
            irq_mask_reg <= `HSW_IRQ_RST;
            irq_reg      <= 1'b0;
        end
        else
        begin
            loop_reg     <= loop_next;
            err_reg      <= err_next;
            alarm_reg    <= alarm_next;
            hold1_d_reg  <= hold_one;
            hold2_d_reg  <= hold_two;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg      <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic [5:0]         awidx_reg, awidx_next;
    logic [31:0]        wdata_next;
    logic [3:0]         wstrb_reg, wstrb_next;
    logic               aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic               awready_reg, awready_next, wready_reg, wready_next;
    logic               bvalid_reg, bvalid_next;
    hsw_pkg::hsw_resp_t bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic               arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [31:0]        rdata_reg, rdata_next;
    logic [5:0]         aridx;
    logic               ar_take, do_write;

    assign aridx = s_axi_araddr[7:2];

    always_comb
    begin
        awidx_next   = awidx_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        aw_full_next = aw_full_reg;
        w_full_next  = w_full_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        mask_wr      = 1'b0;
        if (s_axi_awvalid && awready_reg)
        begin
            awidx_next   = s_axi_awaddr[7:2];
            aw_full_next = 1'b1;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
            w_full_next = 1'b1;
        end
        if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        do_write = aw_full_reg && w_full_reg && !bvalid_reg;
        if (do_write)
        begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            // Only the mask takes writes; status words stay untouched
            if (awidx_reg == `HSW_IDX_IRQ_MASK)
            begin
                mask_wr    = wstrb_reg[0];
                bresp_next = `HSW_RESP_OKAY;
            end
            else
                bresp_next = `HSW_RESP_SLVERR;
        end
        ar_take  = s_axi_arvalid && arready_reg;
        stat_clr = ar_take && aridx == `HSW_IDX_IRQ_STAT;
        if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
        if (ar_take)
        begin
            rvalid_next = 1'b1;
            rresp_next  = `HSW_RESP_OKAY;
            rdata_next  = '0;
            case (aridx)
                `HSW_IDX_HOLD:      rdata_next[15:0] = hold_word;
                `HSW_IDX_LOOP:      rdata_next[3:0] = loop_reg;
                `HSW_IDX_EXP_ERR:   rdata_next[NUNIT-1:0] = err_reg;
                `HSW_IDX_EXP_ALARM: rdata_next[NUNIT-1:0] = alarm_reg;
                `HSW_IDX_IRQ_STAT:  rdata_next[4:0] = irq_stat_reg;
                `HSW_IDX_IRQ_MASK:  rdata_next[4:0] = irq_mask_reg;
                `HSW_IDX_MONITOR:   rdata_next = 32'(mon_one)
                                      | (32'(mon_two) << `HSW_MON_TWO_LSB);
                default:            rresp_next = `HSW_RESP_SLVERR;
            endcase
        end
        awready_next = !aw_full_next;
        wready_next  = !w_full_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awidx_reg   <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `HSW_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= `HSW_RESP_OKAY;
        end
        else
        begin
            awidx_reg   <= awidx_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = irq_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_status_read;
        ar_take && (aridx == `HSW_IDX_HOLD || aridx == `HSW_IDX_LOOP ||
                    aridx == `HSW_IDX_EXP_ERR || aridx == `HSW_IDX_EXP_ALARM);
    endsequence

    a_loop_map: assert property ($stable(loop_err)[*4] |-> loop_reg == loop_err)
        else $error("loop error word does not follow loop inputs");
    a_zero_cross_map: assert property ($stable(unit_zero_cross_err)[*4]
        |-> err_reg == unit_zero_cross_err)
        else $error("expansion error word does not follow zero-cross inputs");
    a_alarm_map: assert property ($stable({unit_burnout, unit_overcurrent,
        unit_ssr_short, unit_ssr_open})[*4] |-> alarm_reg == (unit_burnout
        | unit_overcurrent | unit_ssr_short | unit_ssr_open))
        else $error("expansion alarm word does not follow alarm inputs");
    a_unused_zero: assert property (s_status_read
        |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000
            && ((s_axi_rdata & 32'h0000_ffee) == 32'h0 || $past(aridx) != `HSW_IDX_HOLD))
        else $error("unused status bits read nonzero");
    a_ro_write: assert property (do_write && awidx_reg != `HSW_IDX_IRQ_MASK
        |=> s_axi_bresp == `HSW_RESP_SLVERR && $stable(irq_mask_reg))
        else $error("write to read-only word changed state");
    a_read_clear: assert property (stat_clr && ev == 5'h00 |=> irq_stat_reg == 5'h00)
        else $error("interrupt status not cleared by read");
    a_set_wins: assert property (ev[`HSW_EV_HOLD_ONE] |=> irq_stat_reg[`HSW_EV_HOLD_ONE])
        else $error("hold event lost");
    a_irq_level: assert property (##1 irq == |(irq_stat_reg & irq_mask_reg))
        else $error("interrupt level does not match masked status");

endmodule

`default_nettype wire

// *** verification/hsw_status_top_tb.sv ***
// Self-checking bench for the heater unit status words.
// Assumes hsw_cfg.svh on the include path and the hold window shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "hsw_cfg.svh"

module hsw_status_top_tb;
    localparam logic [7:0] A_HOLD = {`HSW_IDX_HOLD, 2'b00};
    localparam logic [7:0] A_LOOP = {`HSW_IDX_LOOP, 2'b00};
    localparam logic [7:0] A_ERR  = {`HSW_IDX_EXP_ERR, 2'b00};
    localparam logic [7:0] A_ALM  = {`HSW_IDX_EXP_ALARM, 2'b00};
    localparam logic [7:0] A_STAT = {`HSW_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_MASK = {`HSW_IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_MON  = {`HSW_IDX_MONITOR, 2'b00};
    localparam logic [1:0] OK     = `HSW_RESP_OKAY;
    localparam logic [1:0] SE     = `HSW_RESP_SLVERR;

    logic        clock = 1'b0;
    logic        rst_b;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, loop_err;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ctrl_out_on, sensor_present;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq;
    logic [11:0] cur_sample_one, cur_sample_two;
    logic [7:0]  unit_zero_cross_err, unit_freq_err, unit_burnout;
    logic [7:0]  unit_overcurrent, unit_ssr_short, unit_ssr_open;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;

    hsw_status_top #(.MIN_ON(22'd20)) i_dut (
        .clock(clock), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ctrl_out_on(ctrl_out_on),
        .sensor_present(sensor_present), .cur_sample_one(cur_sample_one),
        .cur_sample_two(cur_sample_two), .loop_err(loop_err),
        .unit_zero_cross_err(unit_zero_cross_err), .unit_freq_err(unit_freq_err),
        .unit_burnout(unit_burnout), .unit_overcurrent(unit_overcurrent),
        .unit_ssr_short(unit_ssr_short), .unit_ssr_open(unit_ssr_open), .irq(irq)
    );

    always #12.5 clock = ~clock;

    // ----------------------------------------------------------------
    // Run control and bus cycles
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            $display("[ERR] %0t run hung", $time);
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Address and data offered together, released each on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got)
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                got = 1'b1;
                s_axi_bready <= 1'b0;
                chk({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got)
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                got = 1'b1;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, e);
                chk({30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
    endtask

    task automatic pulse(input int n);
        @(posedge clock);
        ctrl_out_on <= 2'b11;
        wt(n);
        ctrl_out_on <= 2'b00;
        wt(8);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(A_HOLD, 32'h0, OK);
        rd(A_MASK, 32'h0, OK);
        rd(A_STAT, 32'h0, OK);
        rd(8'h00, 32'h0, SE);
    endtask

    task automatic t_loop();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            loop_err <= 4'(1 << i);
            wt(6);
            rd(A_LOOP, 32'(1 << i), OK);
        end
        wr(A_LOOP, 32'hffff_ffff, SE);
        rd(A_LOOP, 32'h8, OK);
        loop_err <= 4'h0;
    endtask

    task automatic t_exp();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            unit_zero_cross_err <= 8'(1 << i);
            unit_burnout <= (i % 4 == 0) ? 8'(1 << i) : 8'h0;
            unit_overcurrent <= (i % 4 == 1) ? 8'(1 << i) : 8'h0;
            unit_ssr_short <= (i % 4 == 2) ? 8'(1 << i) : 8'h0;
            unit_ssr_open <= (i % 4 == 3) ? 8'(1 << i) : 8'h0;
            wt(6);
            rd(A_ERR, 32'(1 << i), OK);
            rd(A_ALM, 32'(1 << i), OK);
        end
        wr(A_ALM, 32'h0, SE);
        rd(A_ALM, 32'h80, OK);
        {unit_zero_cross_err, unit_burnout, unit_overcurrent} <= 24'h0;
        {unit_ssr_short, unit_ssr_open} <= 16'h0;
    endtask

    task automatic t_hold();
        cur_sample_one <= 12'h0a5;
        cur_sample_two <= 12'h03c;
        pulse(5);
        rd(A_HOLD, 32'h11, OK);
        pulse(30);
        rd(A_HOLD, 32'h0, OK);
        rd(A_MON, 32'h003c_00a5, OK);
        sensor_present <= 2'b01;
        cur_sample_two <= 12'h777;
        pulse(30);
        rd(A_HOLD, 32'h10, OK);
        rd(A_MON, 32'h003c_00a5, OK);
        sensor_present <= 2'b11;
        cur_sample_one <= 12'h0f0;
        pulse(30);
        rd(A_MON, 32'h0777_00f0, OK);
        unit_freq_err <= 8'h20;
        cur_sample_one <= 12'h555;
        pulse(30);
        rd(A_HOLD, 32'h11, OK);
        rd(A_MON, 32'h0777_00f0, OK);
        unit_freq_err <= 8'h00;
    endtask

    task automatic t_irq();
        rd(A_STAT, 32'h1f, OK);
        wr(A_MASK, 32'h08, OK);
        rd(A_MASK, 32'h08, OK);
        loop_err <= 4'h2;
        wt(8);
        chk({31'h0, irq}, 32'h0);
        unit_zero_cross_err <= 8'h01;
        wt(8);
        chk({31'h0, irq}, 32'h1);
        rd(A_STAT, 32'h0c, OK);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        rd(A_STAT, 32'h0, OK);
    endtask

    initial
    begin
        rst_b = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {ctrl_out_on, loop_err, cur_sample_one, cur_sample_two} = '0;
        sensor_present = 2'b11;
        {unit_zero_cross_err, unit_freq_err, unit_burnout} = '0;
        {unit_overcurrent, unit_ssr_short, unit_ssr_open} = '0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_loop();
        t_exp();
        t_hold();
        t_irq();
        conclude();
    end
endmodule

`default_nettype wire
